// ---- design/sirf_pkg.sv ----
package sirf_pkg;
   // register map: printed offset 0x0005 is not a multiple of four
   localparam logic [7:0]  SICS_IDX       = 8'h05;
   localparam logic [31:0] SICS_ADDR      = 32'h00000014;
   localparam logic [7:0]  SICS_RESET     = 8'h00;
   localparam int          WARN_IE_BIT    = 6;
   localparam int          WARN_FLAG_BIT  = 5;
   localparam int          DROP_RF_BIT    = 4;
   localparam int          WDG_RF_BIT     = 0;
   // timing
   localparam int          CLK_HZ         = 10000000;
   localparam int          RST_OUT_NS     = 20000;
   localparam int          RST_OUT_CYC    =
      (RST_OUT_NS * (CLK_HZ / 1000000) + 999) / 1000;
   localparam int          DLY_LONG_CYC   = 4096;
   localparam int          DLY_SHORT_CYC  = 256;
   localparam int          FETCH_CYC      = 2;
   localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

   typedef enum logic [3:0] {
      SIRF_RUN    = 4'h1,
      SIRF_ACTIVE = 4'h2,
      SIRF_DELAY  = 4'h4,
      SIRF_FETCH  = 4'h8
   } sirf_state_t;

   // option byte settings
   typedef struct packed {
      logic       drop_enable;
      logic [1:0] drop_level;
      logic       short_delay;
   } sirf_option_t;

   // low power mode inputs
   typedef struct packed {
      logic wait_mode;
      logic halt_mode;
   } sirf_power_t;
endpackage : sirf_pkg

// ---- design/sirf_top.sv ----
// Function
// - drop reset pulls reset pin low throughout
// - watchdog underflow drives pin low minimum width
// - delay 4096 or short cycles after active
// - vector fetch phase lasts two cycles
// - static reset while drop comparator reports low
// - threshold low/medium/high from option byte
// - disabled drop detector produces no reset
// - warning logic active only with drop enabled
// - bit 5 warning flag read only hardware
// - interrupt on every warning flag change
// - bit 6 warning interrupt enable read/write
// - pending interrupt cleared on service entry
// - no rising interrupt during reset delay
// - enabling before crossing gives two interrupts
// - enabling after crossing gives one interrupt
// - wait mode no effect, interrupt wakes
// - halt freezes register, no wake
// - interrupt needs enable and clear mask
// - bit 4 drop flag set hw, sw zero clears
// - drop flag survives pin and watchdog resets
// - drop flag undefined when detector disabled
// - bit 0 watchdog flag, cleared by drop reset
// - flags encode last reset source
// - bit 7 reads zero, bits 3:1 kept clear
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module sirf_top (
   input  wire logic                  clk,
   input  wire logic                  nrst,
   // ahb-lite slave
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic [31:0]           hwdata,
   input  wire logic                  hready,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   // analog and outside inputs
   input  wire logic                  drop_cmp_low,
   input  wire logic                  warn_cmp_low,
   input  wire logic                  wdg_underflow,
   input  wire logic                  rst_pin_in,
   input  wire sirf_pkg::sirf_option_t option,
   input  wire sirf_pkg::sirf_power_t  power,
   input  wire logic                  cc_int_mask,
   input  wire logic                  warn_irq_ack,
   // outputs
   output logic                       rst_pin_out,
   output logic                       rst_pin_oe,
   output logic                       cpu_rst_n,
   output logic                       fetch_phase,
   output logic                       warn_irq,
   output logic                       warn_wake,
   output logic [1:0]                 drop_level_sel
);
   // synchronisers: stage 1 read only by stage 2
   logic [2:0] drop_sync_ff;
   logic [2:0] warn_sync_ff;
   logic [2:0] pin_sync_ff;
   logic       drop_low_ff;
   logic       warn_low_ff;
   logic       pin_low_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drop_sync_ff <= 3'h0;
         warn_sync_ff <= 3'h0;
         pin_sync_ff  <= 3'h0;
      end else begin
         drop_sync_ff <= {drop_sync_ff[1:0], drop_cmp_low};
         warn_sync_ff <= {warn_sync_ff[1:0], warn_cmp_low};
         pin_sync_ff  <= {pin_sync_ff[1:0], ~rst_pin_in};
      end
   end

   // a change counts once stages two and three agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drop_low_ff <= 1'h0;
         warn_low_ff <= 1'h0;
         pin_low_ff  <= 1'h0;
      end else begin
         if (drop_sync_ff[2] == drop_sync_ff[1])
            drop_low_ff <= drop_sync_ff[2];
         if (warn_sync_ff[2] == warn_sync_ff[1])
            warn_low_ff <= warn_sync_ff[2];
         if (pin_sync_ff[2] == pin_sync_ff[1])
            pin_low_ff <= pin_sync_ff[2];
      end
   end

   // the reset pin is ours to drive during the sequence, so its
   // read-back is only an outside reset once the pin has been
   // released long enough for the synchroniser and filter to see
   // the pull-up; otherwise the sequence would retrigger itself
   logic [2:0] pin_quiet_ff;
   logic       pin_ext;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         pin_quiet_ff <= 3'h0;
      else if (rst_pin_oe)
         pin_quiet_ff <= 3'h0;
      else if (pin_quiet_ff != 3'h7)
         pin_quiet_ff <= pin_quiet_ff + 3'h1;
   end

   // outside pin reset: filtered low level with pin released
   assign pin_ext = pin_low_ff && (pin_quiet_ff == 3'h7);

   // disabled detector never resets
   logic drop_rst;
   assign drop_rst = option.drop_enable & drop_low_ff;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         drop_level_sel <= 2'h0;
      else
         drop_level_sel <= option.drop_level;
   end

   // reset sequencer
   sirf_pkg::sirf_state_t state_ff;
   sirf_pkg::sirf_state_t nxt_state;
   logic [12:0]           cnt_ff;
   logic [12:0]           nxt_cnt;
   logic                  wdg_hold_ff;
   logic                  src_drop_ff;
   logic                  src_wdg_ff;
   logic                  delay_done;
   logic                  pulse_done;

   assign pulse_done = cnt_ff >= 13'(sirf_pkg::RST_OUT_CYC - 1);
   assign delay_done = option.short_delay ?
      (cnt_ff >= 13'(sirf_pkg::DLY_SHORT_CYC - 1)) :
      (cnt_ff >= 13'(sirf_pkg::DLY_LONG_CYC - 1));

   always_comb begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff + 13'h1;
      unique case (state_ff)
         sirf_pkg::SIRF_RUN: begin
            nxt_cnt = 13'h0;
            if (drop_rst || wdg_underflow || pin_ext)
               nxt_state = sirf_pkg::SIRF_ACTIVE;
         end
         sirf_pkg::SIRF_ACTIVE: begin
            // active lasts while source holds, watchdog for min width
            if (drop_rst || pin_ext ||
                (wdg_hold_ff && !pulse_done))
               nxt_cnt = wdg_hold_ff ? cnt_ff + 13'h1 : 13'h0;
            else begin
               nxt_cnt   = 13'h0;
               nxt_state = sirf_pkg::SIRF_DELAY;
            end
         end
         sirf_pkg::SIRF_DELAY: begin
            if (drop_rst || pin_ext) begin
               nxt_cnt   = 13'h0;
               nxt_state = sirf_pkg::SIRF_ACTIVE;
            end else if (delay_done) begin
               nxt_cnt   = 13'h0;
               nxt_state = sirf_pkg::SIRF_FETCH;
            end
         end
         sirf_pkg::SIRF_FETCH: begin
            if (drop_rst || pin_ext) begin
               nxt_cnt   = 13'h0;
               nxt_state = sirf_pkg::SIRF_ACTIVE;
            end else if (cnt_ff >= 13'(sirf_pkg::FETCH_CYC - 1)) begin
               nxt_cnt   = 13'h0;
               nxt_state = sirf_pkg::SIRF_RUN;
            end
         end
         default: begin
            nxt_cnt   = 13'h0;
            nxt_state = sirf_pkg::SIRF_ACTIVE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= sirf_pkg::SIRF_ACTIVE;
         cnt_ff   <= 13'h0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
      end
   end

   // remembers watchdog start and which sources acted
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         wdg_hold_ff <= 1'h0;
         src_drop_ff <= 1'h0;
         src_wdg_ff  <= 1'h0;
      end else if (state_ff == sirf_pkg::SIRF_RUN) begin
         wdg_hold_ff <= wdg_underflow & ~drop_rst & ~pin_ext;
         src_drop_ff <= drop_rst;
         src_wdg_ff  <= wdg_underflow & ~drop_rst & ~pin_ext;
      end else begin
         if (state_ff == sirf_pkg::SIRF_ACTIVE && pulse_done)
            wdg_hold_ff <= 1'h0;
         if (drop_rst)
            src_drop_ff <= 1'h1;
      end
   end

   // pin low through active and delay phases
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_pin_out <= 1'h0;
         rst_pin_oe  <= 1'h1;
         cpu_rst_n   <= 1'h0;
         fetch_phase <= 1'h0;
      end else begin
         rst_pin_out <= 1'h0;
         rst_pin_oe  <= (nxt_state == sirf_pkg::SIRF_ACTIVE) ||
                        (nxt_state == sirf_pkg::SIRF_DELAY);
         cpu_rst_n   <= (nxt_state == sirf_pkg::SIRF_RUN);
         fetch_phase <= (nxt_state == sirf_pkg::SIRF_FETCH);
      end
   end

   // reset flags, updated as the sequence leaves active
   logic leave_active;
   logic drop_rf_ff;
   logic wdg_rf_ff;
   logic warn_ie_ff;
   logic warn_flag_ff;
   logic warn_pend_ff;
   logic wr_sel_ff;
   logic wr_cmd;
   logic halted;

   assign leave_active = (state_ff == sirf_pkg::SIRF_ACTIVE) &&
                         (nxt_state == sirf_pkg::SIRF_DELAY);
   assign halted = power.halt_mode;

   // bus slave: zero wait states
   logic bus_take;
   assign bus_take = hsel && hready && htrans == sirf_pkg::HTRANS_NONSEQ;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         wr_sel_ff <= 1'h0;
      else
         wr_sel_ff <= bus_take && hwrite &&
                      haddr == sirf_pkg::SICS_ADDR;
   end
   assign wr_cmd = wr_sel_ff && !halted;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         drop_rf_ff <= 1'h0;
         wdg_rf_ff  <= 1'h0;
      end else if (leave_active) begin
         // drop flag kept through later resets
         if (src_drop_ff) begin
            drop_rf_ff <= 1'h1;
            wdg_rf_ff  <= 1'h0;
         end else if (src_wdg_ff)
            wdg_rf_ff  <= 1'h1;
         else
            wdg_rf_ff  <= 1'h0;
      end else if (wr_cmd) begin
         if (!hwdata[sirf_pkg::DROP_RF_BIT])
            drop_rf_ff <= 1'h0;
         if (!hwdata[sirf_pkg::WDG_RF_BIT])
            wdg_rf_ff  <= 1'h0;
      end
   end

   // warning flag; frozen in halt, idle without drop detector
   logic warn_active;
   assign warn_active = option.drop_enable &&
                        state_ff == sirf_pkg::SIRF_RUN;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         warn_flag_ff <= 1'h0;
      else if (!option.drop_enable)
         warn_flag_ff <= 1'h0;
      else if (!halted)
         warn_flag_ff <= warn_low_ff;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         warn_ie_ff <= 1'h0;
      else if (wr_cmd)
         warn_ie_ff <= hwdata[sirf_pkg::WARN_IE_BIT];
   end

   // pending event: flag toggle, or enable rising while flag high
   logic warn_event;
   logic ie_rise;
   assign ie_rise = wr_cmd && !warn_ie_ff &&
                    hwdata[sirf_pkg::WARN_IE_BIT] && warn_flag_ff;
   assign warn_event = warn_active && !halted &&
      ((warn_flag_ff != warn_low_ff) || ie_rise);

   // set wins over the acknowledge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         warn_pend_ff <= 1'h0;
      else if (!option.drop_enable || state_ff != sirf_pkg::SIRF_RUN)
         warn_pend_ff <= 1'h0;
      else if (warn_event)
         warn_pend_ff <= 1'h1;
      else if (warn_irq_ack)
         warn_pend_ff <= 1'h0;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         warn_irq  <= 1'h0;
         warn_wake <= 1'h0;
      end else begin
         warn_irq  <= warn_pend_ff && warn_ie_ff && !cc_int_mask
                      && !warn_irq_ack;
         warn_wake <= warn_pend_ff && warn_ie_ff &&
                      power.wait_mode && !halted;
      end
   end

   // read data: bit 7 and 3:1 zero
   // captured as the address phase is taken, so it stands through
   // the whole data phase and does not move at its closing edge
   // other addresses read as zero
   // drop flag reads 0 when detector disabled
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst)
         hrdata <= 32'h00000000;
      else if (bus_take && !hwrite) begin
         hrdata <= 32'h00000000;
         if (haddr == sirf_pkg::SICS_ADDR) begin
            hrdata[sirf_pkg::WARN_IE_BIT]   <= warn_ie_ff;
            hrdata[sirf_pkg::WARN_FLAG_BIT] <= warn_flag_ff;
            hrdata[sirf_pkg::DROP_RF_BIT]   <=
               drop_rf_ff & option.drop_enable;
            hrdata[sirf_pkg::WDG_RF_BIT]    <= wdg_rf_ff;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         hreadyout <= 1'h1;
         hresp     <= 1'h0;
      end else begin
         hreadyout <= 1'h1;
         hresp     <= 1'h0;
      end
   end
endmodule : sirf_top

// ---- sim/sirf_checker.sv ----
`timescale 1ns/1ps
module sirf_checker (
   input wire logic                   clk,
   input wire logic                   nrst,
   input wire logic                   drop_cmp_low,
   input wire logic                   wdg_underflow,
   input wire sirf_pkg::sirf_option_t option,
   input wire sirf_pkg::sirf_power_t  power,
   input wire logic                   cc_int_mask,
   input wire logic                   warn_irq_ack,
   input wire logic                   rst_pin_oe,
   input wire logic                   cpu_rst_n,
   input wire logic                   fetch_phase,
   input wire logic                   warn_irq,
   input wire logic                   warn_wake,
   input wire logic [1:0]             drop_level_sel,
   input wire logic                   hreadyout,
   input wire logic                   hresp
);
   logic [15:0] oe_len_ff;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // length of the current pin low pulse
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst || !rst_pin_oe) oe_len_ff <= 16'h0000;
      else if (oe_len_ff != 16'hFFFF) oe_len_ff <= oe_len_ff + 16'h0001;
   end
   a_drop_pin_low: assert property (
      (option.drop_enable && drop_cmp_low) [*8] |-> rst_pin_oe)
      else $error("pin not low under supply drop");
   a_wdg_start: assert property (
      wdg_underflow && cpu_rst_n |-> ##[1:2] rst_pin_oe)
      else $error("watchdog underflow did not start reset");
   a_pulse_min: assert property (
      $fell(rst_pin_oe) |-> oe_len_ff >= sirf_pkg::RST_OUT_CYC)
      else $error("reset pin pulse too short");
   a_fetch_two: assert property (
      $rose(fetch_phase) |=> fetch_phase ##1 !fetch_phase)
      else $error("fetch phase not two cycles");
   a_mask_blocks: assert property (
      $rose(warn_irq) |-> !$past(cc_int_mask))
      else $error("interrupt raised while masked");
   a_ack_clears: assert property (
      warn_irq && warn_irq_ack |-> ##[1:2] !warn_irq)
      else $error("interrupt not cleared on service entry");
   a_level_pass: assert property (
      1'b1 |=> drop_level_sel == $past(option.drop_level))
      else $error("threshold select differs from option");
   a_halt_nowake: assert property (
      power.halt_mode |=> !warn_wake)
      else $error("wake raised in halt");
   a_warn_off: assert property (
      !option.drop_enable |-> !warn_irq && !warn_wake)
      else $error("warning active with detector disabled");
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or error response");
   c_fetch: cover property ($rose(fetch_phase));
   c_irq: cover property ($rose(warn_irq));
   c_wdg: cover property (wdg_underflow && cpu_rst_n);
endmodule : sirf_checker
bind sirf_top sirf_checker u_chk (.clk, .nrst, .drop_cmp_low,
   .wdg_underflow, .option, .power, .cc_int_mask, .warn_irq_ack,
   .rst_pin_oe, .cpu_rst_n, .fetch_phase, .warn_irq, .warn_wake,
   .drop_level_sel, .hreadyout, .hresp);

// ---- sim/sirf_partner.sv ----
`timescale 1ns/1ps
module sirf_partner (
   input  wire logic clk,
   input  wire logic rst_pin_oe,
   input  wire logic rst_pin_out,
   input  wire logic ext_low,
   input  wire logic drop_req,
   input  wire logic warn_req,
   input  wire logic wdg_req,
   output logic      drop_cmp_low = 1'b0,
   output logic      warn_cmp_low = 1'b0,
   output logic      wdg_underflow = 1'b0,
   output wire logic rst_pin_in
);
   // open drain pin with pull-up
   assign rst_pin_in = !((rst_pin_oe && !rst_pin_out) || ext_low);
   // comparators switch off the clock edge
   always @(drop_req) drop_cmp_low <= #37 drop_req;
   always @(warn_req) warn_cmp_low <= #37 warn_req;
   always @(posedge clk) wdg_underflow <= wdg_req && !wdg_underflow;
endmodule : sirf_partner

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin err_count++; \
   $display("unexpected %0t: got %h want %h", $time, a, e); end end
module testbench;
   logic        clk, nrst, hsel, hwrite, hreadyout, hresp, cc_int_mask;
   logic        warn_irq_ack, rst_pin_out, rst_pin_oe, cpu_rst_n;
   logic        fetch_phase, warn_irq, warn_wake, drop_cmp_low;
   logic        warn_cmp_low, wdg_underflow, rst_pin_in, ext_low;
   logic        drop_req, warn_req, wdg_req;
   logic [1:0]  htrans, drop_level_sel;
   logic [31:0] haddr, hwdata, hrdata, d;
   sirf_pkg::sirf_option_t opt;
   sirf_pkg::sirf_power_t  pwr;
   int          err_count, n_tests, cyc, seed;
   localparam logic [31:0] A = sirf_pkg::SICS_ADDR;
   sirf_top u_dut (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'h2), .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
      .hresp, .drop_cmp_low, .warn_cmp_low, .wdg_underflow, .rst_pin_in,
      .option(opt), .power(pwr), .cc_int_mask, .warn_irq_ack,
      .rst_pin_out, .rst_pin_oe, .cpu_rst_n, .fetch_phase, .warn_irq,
      .warn_wake, .drop_level_sel);
   sirf_partner u_far (.clk, .rst_pin_oe, .rst_pin_out, .ext_low,
      .drop_req, .warn_req, .wdg_req, .drop_cmp_low, .warn_cmp_low,
      .wdg_underflow, .rst_pin_in);
   function automatic logic [31:0] ex(input logic ie, wf, df, wd);
      return {24'h000000, 1'h0, ie, wf, df, 3'h0, wd};
   endfunction : ex
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   task automatic xfer(input logic w, input logic [31:0] a, dw,
                       output logic [31:0] r);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= sirf_pkg::HTRANS_NONSEQ;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= dw;
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask : xfer
   task automatic wr(input logic [31:0] a, dw);
      logic [31:0] r;
      xfer(1'b1, a, dw, r);
   endtask : wr
   task automatic rd(input logic [31:0] a, e);
      logic [31:0] r;
      xfer(1'b0, a, 32'h00000000, r);
      `CHK(r, e)
   endtask : rd
   task automatic dly_chk(input int lo);
      int n;
      n = 0;
      while (fetch_phase !== 1'b1 && n < 6000) begin
         @(posedge clk);
         n++;
      end
      `CHK(n + 4 >= lo && n <= lo + 12, 1'b1)
      repeat (4) @(posedge clk);
   endtask : dly_chk
   task automatic irq_chk(input logic e);
      logic s;
      s = 1'b0;
      repeat (12) begin
         @(posedge clk);
         if (warn_irq === 1'b1) s = 1'b1;
      end
      `CHK(s, e)
      warn_irq_ack <= s;
      @(posedge clk);
      warn_irq_ack <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK(warn_irq, 1'b0)
   endtask : irq_chk
   task automatic do_reset(input logic en, sd, input logic [1:0] lv);
      @(posedge clk);
      opt <= '{en, lv, sd};
      nrst <= 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      dly_chk(sd ? 256 : 4096);
   endtask : do_reset
   task automatic wdg_hit;
      wdg_req <= 1'b1;
      @(posedge clk);
      wdg_req <= 1'b0;
      dly_chk(sirf_pkg::RST_OUT_CYC + 4096);
   endtask : wdg_hit
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 60000) begin
         err_count++;
         conclude;
      end
   end
   initial begin
      {nrst, hsel, hwrite, cc_int_mask, warn_irq_ack, ext_low} = 6'h00;
      {drop_req, warn_req, wdg_req, pwr} = 5'h00;
      {htrans, haddr, hwdata, opt} = 70'h0;
      {err_count, n_tests, cyc} = 3'h0;
      seed = 32'h44f3;
      do_reset(1'b1, 1'b0, 2'h1);
      rd(A, ex(0, 0, 0, 0));
      wr(A + 32'h4, 32'h40);
      rd(A + 32'h4, 32'h0);
      repeat (4) begin
         d = $random(seed) & 32'h00000071;
         wr(A, d);
         rd(A, ex(d[6], 0, 0, 0));
      end
      wr(A, 32'h40);
      warn_req <= 1'b1;
      irq_chk(1'b1);
      rd(A, ex(1, 1, 0, 0));
      warn_req <= 1'b0;
      irq_chk(1'b1);
      cc_int_mask <= 1'b1;
      warn_req <= 1'b1;
      irq_chk(1'b0);
      cc_int_mask <= 1'b0;
      irq_chk(1'b1);
      wr(A, 32'h0);
      wr(A, 32'h40);
      irq_chk(1'b1);
      warn_req <= 1'b0;
      irq_chk(1'b1);
      wr(A, 32'h0);
      wr(A, 32'h40);
      irq_chk(1'b0);
      pwr.wait_mode <= 1'b1;
      warn_req <= 1'b1;
      repeat (12) @(posedge clk);
      `CHK(warn_wake, 1'b1)
      irq_chk(1'b1);
      pwr <= 2'h1;
      wr(A, 32'h0);
      warn_req <= 1'b0;
      repeat (12) @(posedge clk);
      pwr <= 2'h0;
      irq_chk(1'b1);
      rd(A, ex(1, 0, 0, 0));
      wr(A, 32'h0);
      wdg_hit;
      rd(A, ex(0, 0, 0, 1));
      drop_req <= 1'b1;
      repeat (20) @(posedge clk);
      `CHK(rst_pin_oe, 1'b1)
      drop_req <= 1'b0;
      dly_chk(4096);
      rd(A, ex(0, 0, 1, 0));
      wdg_hit;
      rd(A, ex(0, 0, 1, 1));
      wr(A, 32'h0);
      rd(A, ex(0, 0, 0, 0));
      ext_low <= 1'b1;
      repeat (20) @(posedge clk);
      ext_low <= 1'b0;
      // pin reset starts its delay on the edge, not on release
      dly_chk(4080);
      rd(A, ex(0, 0, 0, 0));
      do_reset(1'b0, 1'b1, 2'h2);
      wr(A, 32'h40);
      drop_req <= 1'b1;
      warn_req <= 1'b1;
      irq_chk(1'b0);
      `CHK(rst_pin_oe, 1'b0)
      drop_req <= 1'b0;
      warn_req <= 1'b0;
      do_reset(1'b1, 1'b1, 2'h3);
      conclude;
   end
endmodule : testbench
